// ==== ccpce_pkg.sv ====
// constants, types and helpers of the compare event trigger block
`default_nettype none

package ccpce_pkg;

   // ****************************************
   // bus and data widths
   // ****************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int MODE_W = 4;
   localparam int INT_W = 2;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_CTL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CMP_LO = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_CMP_HI = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_CNT_LO = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_CNT_HI = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_TCTL = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_ALT = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATE = 4'h9;

   // ****************************************
   // field positions
   // ****************************************
   localparam int TCTL_ON_BIT = 0;
   localparam int ALT_SEL_BIT = 0;
   localparam int INT_MATCH_BIT = 0;
   localparam int INT_OVF_BIT = 1;
   localparam int ST_MATCH_BIT = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ST_OWN_BIT = 2;

   // ****************************************
   // reset values and count limit
   // ****************************************
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [INT_W-1:0] INT_ZERO = 2'h0;

   // ****************************************
   // compare modes
   // ****************************************
   typedef enum logic [MODE_W-1:0] {
      CCPCE_MODE_OFF = 4'b0000,
      CCPCE_MODE_TOGGLE = 4'b0010,
      CCPCE_MODE_SET = 4'b1000,
      CCPCE_MODE_CLEAR = 4'b1001,
      CCPCE_MODE_SWINT = 4'b1010,
      CCPCE_MODE_TRIG = 4'b1011
   } ccpce_mode_t;

   // true in the modes that own the output pin
   function automatic logic ccpce_pin_mode(input ccpce_mode_t m);
      return (m == CCPCE_MODE_TOGGLE) || (m == CCPCE_MODE_SET) || (m == CCPCE_MODE_CLEAR);
   endfunction : ccpce_pin_mode

endpackage : ccpce_pkg

`default_nettype wire

// ==== ccpce_sync.sv ====
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ccpce_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // level moves only once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         dout <= s3_reg;
      end
   end

endmodule : ccpce_sync

`default_nettype wire

// ==== ccpce_irq.sv ====
// sticky interrupt status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module ccpce_irq (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ccpce_pkg::INT_W-1:0] set,
   input wire logic clr_wr,
   input wire logic mask_wr,
   input wire logic [ccpce_pkg::INT_W-1:0] wdata,
   output logic [ccpce_pkg::INT_W-1:0] status,
   output logic [ccpce_pkg::INT_W-1:0] mask,
   output logic irq
);
   import ccpce_pkg::*;

   logic [INT_W-1:0] status_next;
   logic [INT_W-1:0] mask_next;

   // set wins over a write-one clear in the same cycle
   always_comb begin
      status_next = (status & ~(clr_wr ? wdata : INT_ZERO)) | set;
      mask_next = mask_wr ? wdata : mask;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= INT_ZERO;
         mask <= INT_ZERO;
         irq <= 1'b0;
      end else begin
         status <= status_next;
         mask <= mask_next;
         irq <= |(status_next & mask_next);
      end
   end

endmodule : ccpce_irq

`default_nettype wire

// ==== ccpce_top.sv ====
// compare unit with timer, special event trigger and register port
`timescale 1ns/1ps
`default_nettype none

module ccpce_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [ccpce_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ccpce_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ccpce_pkg::DATA_W-1:0] reg_rdata,
   input wire logic timer_clk_pin,
   input wire logic adc_enable,
   output logic adc_start,
   output logic event_trigger,
   output logic timer_overflow,
   input wire logic port_a_out,
   input wire logic port_a_oe,
   input wire logic port_b_out,
   input wire logic port_b_oe,
   output logic pin_a_out,
   output logic pin_a_oe,
   output logic pin_b_out,
   output logic pin_b_oe,
   output logic irq
);
   import ccpce_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ****************************************
   // declarations
   // ****************************************
   ccpce_mode_t mode_reg;
   ccpce_mode_t mode_next;
   logic [CNT_W-1:0] cmp_reg;
   logic [CNT_W-1:0] cmp_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic timer_on_reg;
   logic alt_sel_reg;
   logic match_reg;
   logic match_next;
   logic match_evt;
   logic ovf_set;
   logic latch_reg;
   logic latch_next;
   logic own_next;
   logic tclk_level;
   logic tclk_prev_reg;
   logic tick;
   logic wr_ctl;
   logic wr_cmp_lo;
   logic wr_cmp_hi;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_tctl;
   logic wr_alt;
   logic wr_stat;
   logic wr_mask;
   logic [INT_W-1:0] int_set;
   logic [INT_W-1:0] int_status;
   logic [INT_W-1:0] int_mask;
   logic [DATA_W-1:0] rd_value;

   // ****************************************
   // register write decode
   // ****************************************
   always_comb begin
      wr_ctl = reg_wr && (reg_addr == OFS_CTL);
      wr_cmp_lo = reg_wr && (reg_addr == OFS_CMP_LO);
      wr_cmp_hi = reg_wr && (reg_addr == OFS_CMP_HI);
      wr_cnt_lo = reg_wr && (reg_addr == OFS_CNT_LO);
      wr_cnt_hi = reg_wr && (reg_addr == OFS_CNT_HI);
      wr_tctl = reg_wr && (reg_addr == OFS_TCTL);
      wr_alt = reg_wr && (reg_addr == OFS_ALT);
      wr_stat = reg_wr && (reg_addr == OFS_INT_STAT);
      wr_mask = reg_wr && (reg_addr == OFS_INT_MASK);
   end

   // ****************************************
   // timer clock edge
   // ****************************************
   // the timer clock is sampled, so it must run far below ref_clk
   ccpce_sync u_tclk_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .din(timer_clk_pin),
      .dout(tclk_level)
   );

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tclk_prev_reg <= 1'b0;
      end else begin
         tclk_prev_reg <= tclk_level;
      end
   end

   assign tick = tclk_level && !tclk_prev_reg;

   // ****************************************
   // control registers
   // ****************************************
   always_comb begin
      mode_next = mode_reg;
      if (wr_ctl) begin
         mode_next = ccpce_mode_t'(reg_wdata[MODE_W-1:0]);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= CCPCE_MODE_OFF;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_on_reg <= 1'b0;
      end else if (wr_tctl) begin
         timer_on_reg <= reg_wdata[TCTL_ON_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         alt_sel_reg <= 1'b0;
      end else if (wr_alt) begin
         alt_sel_reg <= reg_wdata[ALT_SEL_BIT];
      end
   end

   // ****************************************
   // compare value
   // ****************************************
   always_comb begin
      cmp_next = cmp_reg;
      if (wr_cmp_lo) begin
         cmp_next[7:0] = reg_wdata;
      end
      if (wr_cmp_hi) begin
         cmp_next[15:8] = reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_reg <= CMP_RST;
      end else begin
         cmp_reg <= cmp_next;
      end
   end

   // ****************************************
   // timer counter
   // ****************************************
   // match_reg is the live equality, so a rewritten compare value
   // seen at the timer edge decides whether the reset still happens
   always_comb begin
      cnt_next = cnt_reg;
      ovf_set = 1'b0;
      if (tick && timer_on_reg) begin
         if ((mode_reg == CCPCE_MODE_TRIG) && match_reg) begin
            cnt_next = CNT_RST;
         end else begin
            cnt_next = cnt_reg + 16'h0001;
            ovf_set = (cnt_reg == CNT_MAX);
         end
      end
      if (wr_cnt_lo) begin
         cnt_next[7:0] = reg_wdata;
      end
      if (wr_cnt_hi) begin
         cnt_next[15:8] = reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= CNT_RST;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // match detection
   // ****************************************
   // equality is judged on next values so the flopped outputs
   // line up with the cycle in which the count equals the compare
   always_comb begin
      match_next = (cnt_next == cmp_next);
      match_evt = match_next && !match_reg;
   end

   // reset values are equal, so the flag starts high and no event fires
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_reg <= 1'b1;
      end else begin
         match_reg <= match_next;
      end
   end

   // ****************************************
   // compare output latch
   // ****************************************
   always_comb begin
      latch_next = latch_reg;
      if (match_evt) begin
         unique case (mode_next)
            CCPCE_MODE_TOGGLE: begin
               latch_next = !latch_reg;
            end
            CCPCE_MODE_SET: begin
               latch_next = 1'b1;
            end
            CCPCE_MODE_CLEAR: begin
               latch_next = 1'b0;
            end
            CCPCE_MODE_OFF, CCPCE_MODE_SWINT, CCPCE_MODE_TRIG: begin
               latch_next = latch_reg;
            end
            default: begin
               latch_next = latch_reg;
            end
         endcase
      end
      if (wr_ctl && (reg_wdata == DATA_ZERO)) begin
         latch_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg <= 1'b0;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // ****************************************
   // special event trigger and adc start
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_trigger <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         event_trigger <= match_evt && (mode_next == CCPCE_MODE_TRIG);
         adc_start <= match_evt && (mode_next == CCPCE_MODE_TRIG) && adc_enable;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_overflow <= 1'b0;
      end else begin
         timer_overflow <= ovf_set;
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   always_comb begin
      int_set = INT_ZERO;
      int_set[INT_MATCH_BIT] = match_evt && (mode_next != CCPCE_MODE_OFF);
      int_set[INT_OVF_BIT] = ovf_set;
   end

   ccpce_irq u_irq (
      .clk(ref_clk),
      .rst_n(rst_n),
      .set(int_set),
      .clr_wr(wr_stat),
      .mask_wr(wr_mask),
      .wdata(reg_wdata[INT_W-1:0]),
      .status(int_status),
      .mask(int_mask),
      .irq(irq)
   );

   // ****************************************
   // pin routing
   // ****************************************
   // direction stays with port logic; software must enable the driver
   assign own_next = ccpce_pin_mode(mode_next);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_a_out <= 1'b0;
         pin_a_oe <= 1'b0;
         pin_b_out <= 1'b0;
         pin_b_oe <= 1'b0;
      end else begin
         pin_a_oe <= port_a_oe;
         pin_b_oe <= port_b_oe;
         if (own_next && !alt_sel_reg) begin
            pin_a_out <= latch_next;
         end else begin
            pin_a_out <= port_a_out;
         end
         if (own_next && alt_sel_reg) begin
            pin_b_out <= latch_next;
         end else begin
            pin_b_out <= port_b_out;
         end
      end
   end

   // ****************************************
   // register read
   // ****************************************
   always_comb begin
      rd_value = DATA_ZERO;
      unique case (reg_addr)
         OFS_CTL: begin
            rd_value[MODE_W-1:0] = mode_reg;
         end
         OFS_CMP_LO: begin
            rd_value = cmp_reg[7:0];
         end
         OFS_CMP_HI: begin
            rd_value = cmp_reg[15:8];
         end
         OFS_CNT_LO: begin
            rd_value = cnt_reg[7:0];
         end
         OFS_CNT_HI: begin
            rd_value = cnt_reg[15:8];
         end
         OFS_TCTL: begin
            rd_value[TCTL_ON_BIT] = timer_on_reg;
         end
         OFS_ALT: begin
            rd_value[ALT_SEL_BIT] = alt_sel_reg;
         end
         OFS_INT_STAT: begin
            rd_value[INT_W-1:0] = int_status;
         end
         OFS_INT_MASK: begin
            rd_value[INT_W-1:0] = int_mask;
         end
         OFS_STATE: begin
            rd_value[ST_MATCH_BIT] = match_reg;
            rd_value[ST_LATCH_BIT] = latch_reg;
            rd_value[ST_OWN_BIT] = ccpce_pin_mode(mode_reg);
         end
         default: begin
            rd_value = DATA_ZERO;
         end
      endcase
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= DATA_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= rd_value;
      end else begin
         reg_rdata <= DATA_ZERO;
      end
   end

endmodule : ccpce_top

`default_nettype wire

// ==== ccpce_top_monitor.sv ====
// port checker of the compare event trigger block
`timescale 1ns/1ps
`default_nettype none

module ccpce_top_monitor (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [ccpce_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ccpce_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ccpce_pkg::DATA_W-1:0] reg_rdata,
   input wire logic adc_enable,
   input wire logic adc_start,
   input wire logic event_trigger,
   input wire logic timer_overflow,
   input wire logic port_a_out,
   input wire logic port_b_out,
   input wire logic port_a_oe,
   input wire logic port_b_oe,
   input wire logic pin_a_out,
   input wire logic pin_b_out,
   input wire logic pin_a_oe,
   input wire logic pin_b_oe,
   input wire logic irq
);
   import ccpce_pkg::*;
   // ****************
   // shadow of written setup
   // ****************
   logic [MODE_W-1:0] mode_reg;
   logic alt_reg;
   logic [INT_W-1:0] msk_reg;
   logic trig_seen_reg;
   logic pm;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= 4'h0;
         alt_reg <= 1'b0;
         msk_reg <= INT_ZERO;
      end else if (reg_wr) begin
         if (reg_addr == OFS_CTL) mode_reg <= reg_wdata[MODE_W-1:0];
         if (reg_addr == OFS_ALT) alt_reg <= reg_wdata[ALT_SEL_BIT];
         if (reg_addr == OFS_INT_MASK) msk_reg <= reg_wdata[INT_W-1:0];
      end
   end
   // any write may legally move count or compare, so it disarms the check
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         trig_seen_reg <= 1'b0;
      end else if (reg_wr) begin
         trig_seen_reg <= 1'b0;
      end else if (event_trigger) begin
         trig_seen_reg <= 1'b1;
      end
   end
   // own decode, not the package helper, so a slip there still shows
   assign pm = (mode_reg == 4'h2) || (mode_reg == 4'h8) || (mode_reg == 4'h9);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ****************
   // properties
   // ****************
   chk_trig_mode_only: assert property (event_trigger |-> mode_reg == CCPCE_MODE_TRIG)
      else $error("trigger pulse outside trigger mode");
   chk_adc_gate: assert property (adc_start |-> event_trigger && $past(adc_enable))
      else $error("adc start without trigger or enable");
   chk_no_ovf_trig: assert property (trig_seen_reg && mode_reg == CCPCE_MODE_TRIG |-> !timer_overflow)
      else $error("overflow pulse in trigger mode");
   chk_pin_released: assert property (!pm ##1 !pm |-> pin_a_out == $past(port_a_out) && pin_b_out == $past(port_b_out))
      else $error("pin taken outside pin modes");
   chk_pin_route: assert property (pm ##1 pm && $stable(alt_reg)
      |-> (alt_reg ? pin_a_out == $past(port_a_out) : pin_b_out == $past(port_b_out)))
      else $error("unselected pin not left to port");
   chk_flag_irq: assert property (event_trigger && msk_reg[INT_MATCH_BIT] |-> irq)
      else $error("match flag missing after trigger");
   chk_one_event: assert property (event_trigger |=> !event_trigger [*4])
      else $error("repeated trigger on one count");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > OFS_STATE |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_irq_masked: assert property (msk_reg == INT_ZERO [*2] |-> !irq)
      else $error("irq with all mask bits clear");
   chk_oe_follow: assert property (pin_a_oe == $past(port_a_oe) && pin_b_oe == $past(port_b_oe))
      else $error("pin enable not taken from port");
endmodule : ccpce_top_monitor

bind ccpce_top ccpce_top_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .adc_enable(adc_enable), .adc_start(adc_start), .event_trigger(event_trigger),
   .timer_overflow(timer_overflow), .port_a_out(port_a_out), .port_b_out(port_b_out),
   .port_a_oe(port_a_oe), .port_b_oe(port_b_oe), .pin_a_out(pin_a_out), .pin_b_out(pin_b_out),
   .pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe), .irq(irq));
`default_nettype wire

// ==== ccpce_far_side.sv ====
// far side model: timer clock source and adc start counter
`timescale 1ns/1ps
`default_nettype none

module ccpce_far_side (
   input wire logic clk,
   input wire logic run,
   input wire logic [1:0] slow,
   input wire logic adc_start,
   output logic tclk,
   output logic [7:0] adc_count
);
   logic [3:0] cnt;
   initial begin
      tclk = 1'b0;
      cnt = 4'h0;
      adc_count = 8'h00;
   end
   // derived from the system clock and parked low between runs
   always @(posedge clk) begin
      if (!run) begin
         tclk <= 1'b0;
         cnt <= 4'h0;
      end else if (cnt >= 4'h5 + {2'h0, slow}) begin
         tclk <= !tclk;
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   always @(posedge clk) if (adc_start) adc_count <= adc_count + 8'h01;
endmodule : ccpce_far_side
`default_nettype wire

// ==== ccpce_top_test.sv ====
// self-checking bench of the compare event trigger block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin bad_count++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, ac); end end

module ccpce_top_test;
   import ccpce_pkg::*;
   logic ref_clk, nrst, reg_wr, reg_rd, adc_enable, adc_start, event_trigger, timer_overflow, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, adc_count, exp_adc, d, d2;
   logic port_a_out, port_a_oe, port_b_out, port_b_oe, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
   logic tclk, tclk_d, run, rnd_on;
   logic [1:0] slow;
   int bad_count = 0, num_checks = 0, ticks = 0, ev_n = 0, ov_n = 0, t_seen, cyc = 0;
   integer seed = 30;
   logic [3:0] modes [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};

   ccpce_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_clk_pin(tclk),
      .adc_enable(adc_enable), .adc_start(adc_start), .event_trigger(event_trigger),
      .timer_overflow(timer_overflow), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
      .port_b_out(port_b_out), .port_b_oe(port_b_oe), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
      .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .irq(irq));
   ccpce_far_side u_far (.clk(ref_clk), .run(run), .slow(slow), .adc_start(adc_start),
      .tclk(tclk), .adc_count(adc_count));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = !ref_clk;
   end
   // ****************
   // watchers and drivers
   // ****************
   always @(posedge ref_clk) begin
      tclk_d <= tclk;
      if (tclk === 1'b1 && tclk_d === 1'b0) ticks++;
      if (event_trigger === 1'b1) ev_n++;
      if (timer_overflow === 1'b1) ov_n++;
      if (rnd_on) {port_a_out, port_a_oe, port_b_out, port_b_oe} <= $random(seed);
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         close_out();
      end
   end

   function automatic logic own_of(input logic [3:0] m);
      return m == 4'h2 || m == 4'h8 || m == 4'h9;
   endfunction : own_of
   // toggle starts from a cleared latch, so it ends high
   function automatic logic latch_of(input logic [3:0] m);
      return m == 4'h2 || m == 4'h8;
   endfunction : latch_of

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
      @(posedge ref_clk);
   endtask : rd

   // w: 0 irq, 1 event count reaches tgt, 2 one timer tick
   task automatic go(input int w, input int tgt);
      int n;
      n = 0;
      ticks = 0;
      run <= 1'b1;
      @(posedge ref_clk);
      while (n < 400 && ((w == 0 && irq !== 1'b1) || (w == 1 && ev_n < tgt) || (w == 2 && ticks < 1))) begin
         @(posedge ref_clk);
         n++;
      end
      t_seen = ticks;
      run <= 1'b0;
      repeat (8) @(posedge ref_clk);
      `CHK("wait", 0, n / 400)
   endtask : go

   task automatic trial(input logic [3:0] m, input int k);
      logic [15:0] b, c;
      logic a;
      int e0;
      b = $random(seed);
      b[15] = 1'b0;
      b[7] = 1'b0;
      c = b + 16'(k);
      a = $random(seed);
      slow <= $random(seed);
      adc_enable <= $random(seed);
      e0 = ev_n;
      wr(OFS_ALT, {7'h00, a});
      wr(OFS_CNT_LO, b[7:0]);
      wr(OFS_CNT_HI, b[15:8]);
      wr(OFS_CMP_LO, c[7:0]);
      wr(OFS_CMP_HI, c[15:8]);
      wr(OFS_CTL, {4'h0, m});
      wr(OFS_TCTL, 8'h01);
      go(0, 0);
      `CHK("ticks", k, t_seen)
      if (m == 4'hb) begin
         rd(OFS_CNT_LO, d);
         `CHK("cnt_hold", c[7:0], d)
         wr(OFS_CMP_LO, c[7:0] + 8'h03);
         go(1, e0 + 2);
         `CHK("ticks_skip", 3, t_seen)
         go(2, 0);
         rd(OFS_CNT_LO, d);
         rd(OFS_CNT_HI, d2);
         `CHK("cnt_restart", 16'h0000, {d2, d})
         if (adc_enable) exp_adc = exp_adc + 8'h02;
      end
      `CHK("events", e0 + (m == 4'hb ? 2 : 0), ev_n)
      `CHK("adc", exp_adc, adc_count)
      rd(OFS_STATE, d);
      `CHK("latch", latch_of(m), d[ST_LATCH_BIT])
      `CHK("own", own_of(m), d[ST_OWN_BIT])
      `CHK("match", m != 4'hb, d[ST_MATCH_BIT])
      if (own_of(m)) `CHK("pin", latch_of(m), a ? pin_b_out : pin_a_out)
      rd(OFS_INT_STAT, d);
      `CHK("flags", 2'h1, d[1:0])
      wr(OFS_TCTL, 8'h00);
      wr(OFS_CTL, 8'h00);
      rd(OFS_STATE, d);
      `CHK("latch_clr", 1'b0, d[ST_LATCH_BIT])
      wr(OFS_INT_STAT, 8'h03);
      rd(OFS_INT_STAT, d);
      `CHK("flags_clr", 8'h00, d)
      `CHK("irq_clr", 1'b0, irq)
      $display("trial mode %h steps %0d done", m, k);
   endtask : trial

   initial begin
      nrst = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      adc_enable = 1'b0;
      {port_a_out, port_a_oe, port_b_out, port_b_oe} = 4'h0;
      run = 1'b0;
      rnd_on = 1'b0;
      slow = 2'h0;
      exp_adc = 8'h00;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rnd_on <= 1'b1;
      rd(4'hc, d);
      `CHK("unmapped", 8'h00, d)
      // overflow in mode off: flag without match flag, then mask and clear
      wr(OFS_INT_MASK, 8'h03);
      wr(OFS_CNT_LO, 8'hfe);
      wr(OFS_CNT_HI, 8'hff);
      wr(OFS_TCTL, 8'h01);
      go(0, 0);
      `CHK("ovf_ticks", 2, t_seen)
      rd(OFS_INT_STAT, d);
      `CHK("ovf_flag", 2'h2, d[1:0])
      `CHK("ovf_pulse", 1, ov_n)
      wr(OFS_INT_MASK, 8'h01);
      repeat (2) @(posedge ref_clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(OFS_INT_MASK, 8'h03);
      repeat (2) @(posedge ref_clk);
      `CHK("irq_unmasked", 1'b1, irq)
      wr(OFS_INT_STAT, 8'h02);
      repeat (2) @(posedge ref_clk);
      `CHK("irq_w1c", 1'b0, irq)
      wr(OFS_TCTL, 8'h00);
      $display("overflow and interrupt test done");
      trial(4'hb, 1);
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 5; i++) begin
            trial(modes[i], 1 + {$random(seed)} % 6);
         end
      end
      `CHK("ovf_total", 1, ov_n)
      close_out();
   end
endmodule : ccpce_top_test
`default_nettype wire
